// *** bench/sacc_comp_model.sv ***
// Comparator model that answers the trial word of the SAR array
`timescale 1ns/1ps
`default_nettype none
module sacc_comp_model (
  input wire logic [17:0] vin, // Held sample as a code
  input wire logic [17:0] dac_trial, // Trial word from the array
  input wire logic busy, // Conversion running
  output logic comp_out // High: sample at or above trial
);
  // MSB-first trial compare
  // Off conversion the comparator sits unbalanced, so it shows noise
  always_comb comp_out = busy ? (vin >= dac_trial) : ~vin[0];
endmodule // sacc_comp_model
`default_nettype wire

// *** bench/tb_sacc_ctrl.sv ***
// Self-checking bench for the SAR conversion control block
`timescale 1ns/1ps
`default_nettype none
module tb_sacc_ctrl;
  import sacc_pkg::*;
  logic ref_clk, rst, cnv_n, pwr_dn, buf_off, comp, busy, lowp, bufen, pdn;
  logic [17:0] vin, trial, dout, doe;
  sacc_rd_ctl_t rc; // Read port controls
  int err_count, n_checks, cyc, k;
  bit noise; // Disturb start and power-down mid-conversion
  logic [17:0] cv [4] = '{18'h0, 18'h3ffff, 18'h20000, 18'h1ffff};
  // Short acquisition keeps the run brief
  sacc_ctrl #(.ACQ_CYC(2)) i_sacc_ctrl (.ref_clk(ref_clk), .rst(rst),
    .convert_start_n(cnv_n), .power_down_input(pwr_dn),
    .reference_buffer_power_down(buf_off), .rd_ctl(rc), .comp_out(comp),
    .busy(busy), .dac_trial(trial), .data_out(dout), .data_oe(doe),
    .core_low_power(lowp), .ref_buf_enable(bufen), .powered_down(pdn));
  sacc_comp_model i_sacc_comp_model (.vin(vin), .dac_trial(trial),
    .busy(busy), .comp_out(comp));
  always #12.5 ref_clk = ~ref_clk;
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [17:0] e,
                     input logic [17:0] g);
    n_checks++;
    if (e !== g) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // Two's complement is the binary code with its top bit flipped
  function automatic logic [17:0] exp_code(logic [17:0] v, logic [1:0] m,
                                           logic c);
    return (m != 2'h0 && !c) ? v ^ 18'h20000 : v;
  endfunction
  // One conversion; read port scrambled throughout, hold keeps start low
  task automatic conv(input logic [17:0] v, input bit hold);
    int n;
    n = 0;
    @(posedge ref_clk);
    vin <= v;
    cnv_n <= 1'b0;
    rc <= 5'($urandom);
    do begin @(posedge ref_clk); #1 n++; end while (busy !== 1'b1 && n < 8);
    chk("busy rise", 1, busy);
    chk("trial msb", 18'h20000, trial);
    n = 0;
    do begin
      @(posedge ref_clk);
      cnv_n <= hold ? 1'b0 : (noise && n < 10) ? n[0] : 1'b1;
      pwr_dn <= noise;
      rc <= 5'($urandom);
      #1 n++;
      if (n == 10) chk("powerdown in busy", 0, pdn);
      if (n == 10) chk("lowp busy", 0, lowp);
    end while (busy === 1'b1 && n < 40);
    chk("busy len", 18'(19), 18'(n));
    chk("lowp acq", 1, lowp);
  endtask
  // Select and read one word, then deselect and expect release
  task automatic rd(input logic [1:0] m, input logic c, input logic [17:0] v);
    logic [17:0] e;
    e = exp_code(v, m, c);
    @(posedge ref_clk);
    rc <= {2'b00, m, c};
    @(posedge ref_clk);
    #1 chk("lowp read", 1, lowp);
    if (m == 2'h3) chk("serial", {17'h0, e[17]}, dout & doe);
    else chk("data", e, dout);
    chk("oe on", (m == 2'h3) ? 18'h00001 : 18'h3ffff, doe);
    @(posedge ref_clk);
    rc <= {2'($urandom_range(1, 3)), m, c};
    @(posedge ref_clk);
    #1 chk("oe off", 0, doe);
  endtask
  // Cycle ceiling cuts a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    logic [17:0] v;
    ref_clk = 0; rst = 1; cnv_n = 1; pwr_dn = 0; buf_off = 0; noise = 0;
    rc = 5'h1f; vin = 0; err_count = 0; n_checks = 0; cyc = 0;
    void'($urandom(32'hfdce));
    repeat (9) @(posedge ref_clk);
    #1 chk("reset busy", 0, busy);
    chk("reset oe", 0, doe);
    @(posedge ref_clk) rst <= 1'b0;
    for (int b = 1; b >= 0; b--) begin
      @(posedge ref_clk) buf_off <= b[0];
      repeat (2) @(posedge ref_clk);
      #1 chk("buf en", 18'(!b[0]), bufen);
    end
    // Corner codes read in every mode and coding
    foreach (cv[i]) begin
      conv(cv[i], 0);
      for (int m = 0; m < 8; m++) rd(m[2:1], m[0], cv[i]);
    end
    repeat (8) begin
      v = 18'($urandom);
      conv(v, 0);
      rd(2'($urandom), 1'($urandom), v);
    end
    // Start held low repeats by itself
    conv(18'h2a5a5, 1);
    k = 0;
    while (busy !== 1'b1 && k < 8) begin @(posedge ref_clk); #1 k++; end
    chk("auto restart", 1, busy);
    @(posedge ref_clk) cnv_n <= 1'b1;
    k = 0;
    while (busy !== 1'b0 && k < 40) begin @(posedge ref_clk); #1 k++; end
    repeat (10) @(posedge ref_clk);
    #1 chk("no restart", 0, busy);
    rd(2'h0, 1'b1, 18'h2a5a5);
    // Start and power-down pulled mid-conversion are ignored
    noise = 1;
    conv(18'h15555, 0);
    noise = 0;
    repeat (3) @(posedge ref_clk);
    #1 chk("powerdown latched", 1, pdn);
    chk("buf off powerdown", 0, bufen);
    @(posedge ref_clk) cnv_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 chk("start in powerdown", 0, busy);
    @(posedge ref_clk);
    cnv_n <= 1'b1;
    pwr_dn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("powerdown clear", 0, pdn);
    rd(2'h1, 1'b0, 18'h15555);
    finish_test();
  end
endmodule // tb_sacc_ctrl
`default_nettype wire

// *** verilog/sacc_ctrl.sv ***
// Conversion sequencer and output port control of an 18-bit SAR converter
// Notes on behaviour
// - Conversion starts only from low convert_start_n
// - Running conversion ignores start; power-down is ignored in CONV but latched in the last busy cycle (DONE)
// - Start works regardless of select and read
// - Held start low auto-repeats after timed acquisition
// - Select or read high tristates all data bus outputs
// - Select and read low drive result out
// - Coding select applies except 18-bit parallel
// - Serial pins share the parallel data bus
// - Low-current state after conversion through acquisition
// - Read port works during low-current acquisition
// - Buffer power-down high selects external reference
// - Form code, then drop busy
// - MSB-first decisions over eighteen weighted elements
`timescale 1ns/1ps
`default_nettype none
`include "sacc_map.svh"
module sacc_ctrl
  import sacc_pkg::*;
#(
  parameter int RES_BITS = `SACC_RES_BITS,
  parameter int ACQ_CYC = `SACC_ACQ_CYC
) (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic convert_start_n, // Start request, active low
  input wire logic power_down_input, // Power-down request
  input wire logic reference_buffer_power_down, // High: external ref
  input wire sacc_rd_ctl_t rd_ctl, // Read port controls
  input wire logic comp_out, // Comparator: input above trial level
  output logic busy, // Conversion in progress
  output logic [RES_BITS-1:0] dac_trial, // Trial word to the array
  output logic [RES_BITS-1:0] data_out, // Shared data bus value
  output logic [RES_BITS-1:0] data_oe, // Drive enables, high drives
  output logic core_low_power, // Converter core in low current
  output logic ref_buf_enable, // Internal reference buffer on
  output logic powered_down // Device held powered down
);
  // Elaboration checks: the timer is 16 bits wide, and a zero count
  // would leave no acquisition time at all
  if (RES_BITS < 8 || RES_BITS > 32) begin : g_bad_res
    $error("RES_BITS out of range");
  end
  if (ACQ_CYC < 1 || ACQ_CYC > 65535) begin : g_bad_acq
    $error("ACQ_CYC out of range");
  end

  sacc_state_t state_r, state_nxt; // Sequencer state
  logic [RES_BITS-1:0] sar_r, sar_nxt; // Trial and decided bits
  logic [RES_BITS-1:0] bit_r, bit_nxt; // One-hot bit under decision
  logic [RES_BITS-1:0] result_r, result_nxt; // Last straight binary code
  logic [15:0] acq_r, acq_nxt; // Acquisition timer
  logic start_prev_r; // Previous start level, for edge detection
  logic pwrdn_r; // Latched power-down request
  logic busy_r, low_r, buf_r; // Registered outputs
  logic [RES_BITS-1:0] dout_r, doe_r; // Registered bus drive

  // Start decode: falling edge while idle, or held low at the end of acquisition
  // no read-port term
  wire start_fall = start_prev_r & ~convert_start_n;
  wire start_held = ~convert_start_n;
  wire last_bit = bit_r[0];
  // Decision of the current bit kept or dropped
  wire [RES_BITS-1:0] decided = comp_out ? sar_r : (sar_r & ~bit_r);
  wire [RES_BITS-1:0] bit_shift = bit_r >> 1;

  // Next-state logic of the sequencer
  always_comb begin
    state_nxt = state_r;
    sar_nxt = sar_r;
    bit_nxt = bit_r;
    result_nxt = result_r;
    acq_nxt = acq_r;
    case (state_r)
      SACC_IDLE: begin
        if (start_fall && !pwrdn_r) begin
          state_nxt = SACC_CONV;
          bit_nxt = {1'b1, {(RES_BITS-1){1'b0}}};
          sar_nxt = {1'b1, {(RES_BITS-1){1'b0}}};
        end
      end
      SACC_CONV: begin
        if (last_bit) begin
          state_nxt = SACC_DONE;
          sar_nxt = decided;
        end else begin
          sar_nxt = decided | bit_shift;
          bit_nxt = bit_shift;
        end
      end
      SACC_DONE: begin
        result_nxt = sar_r;
        acq_nxt = 16'(ACQ_CYC);
        state_nxt = SACC_ACQ;
      end
      SACC_ACQ: begin
        if (acq_r > 16'h0001) begin
          acq_nxt = acq_r - 16'h0001;
        end else if (pwrdn_r) begin
          state_nxt = SACC_IDLE;
        end else if (start_held) begin
          state_nxt = SACC_CONV;
          bit_nxt = {1'b1, {(RES_BITS-1){1'b0}}};
          sar_nxt = {1'b1, {(RES_BITS-1){1'b0}}};
        end else begin
          state_nxt = SACC_IDLE;
        end
      end
      default: state_nxt = SACC_IDLE;
    endcase
  end

  // Output coding and bus drive; read side ignores core state
  // coding except 18-bit mode
  wire use_2c = ~rd_ctl.output_coding_select &
                (rd_ctl.mode != `SACC_MODE_P18);
  wire [RES_BITS-1:0] coded =
    {result_r[RES_BITS-1] ^ use_2c, result_r[RES_BITS-2:0]};
  // select and read gate the bus
  wire rd_active = ~rd_ctl.chip_select_n & ~rd_ctl.read_enable_n;
  // serial mode uses only bit 0 of the shared pins
  wire serial = rd_ctl.mode == `SACC_MODE_SER;
  wire [RES_BITS-1:0] oe_nxt = !rd_active ? '0 :
    serial ? {{(RES_BITS-1){1'b0}}, 1'b1} : '1;
  wire [RES_BITS-1:0] dout_nxt = !rd_active ? '0 :
    serial ? {{(RES_BITS-1){1'b0}}, coded[RES_BITS-1]} : coded;
  wire conv_nxt = (state_nxt == SACC_CONV) || (state_nxt == SACC_DONE);

  // Sequencer registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= SACC_IDLE;
      sar_r <= '0;
      bit_r <= '0;
      result_r <= '0;
      acq_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      sar_r <= sar_nxt;
      bit_r <= bit_nxt;
      result_r <= result_nxt;
      acq_r <= acq_nxt;
    end
  end

  // Power-down latched outside CONV, including the DONE cycle while busy is still high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwrdn_r <= 1'b0;
      start_prev_r <= 1'b1;
    end else begin
      start_prev_r <= convert_start_n;
      if (!conv_nxt && state_r != SACC_CONV) begin
        pwrdn_r <= power_down_input;
      end
    end
  end

  // Registered outputs; read port keeps running in low power
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      low_r <= 1'b1;
      buf_r <= 1'b0;
      dout_r <= '0;
      doe_r <= '0;
    end else begin
      busy_r <= conv_nxt;
      low_r <= !conv_nxt;
      buf_r <= !reference_buffer_power_down && !pwrdn_r;
      dout_r <= dout_nxt;
      doe_r <= oe_nxt;
    end
  end

  assign busy = busy_r;
  assign dac_trial = sar_r;
  assign data_out = dout_r;
  assign data_oe = doe_r;
  assign core_low_power = low_r;
  assign ref_buf_enable = buf_r;
  assign powered_down = pwrdn_r;

  // Sequences used by the checks
  sequence s_start;
    state_r == SACC_IDLE && start_fall && !pwrdn_r;
  endsequence

  // A start from idle raises busy next cycle
  property p_start_busy;
    @(posedge ref_clk) disable iff (rst) s_start |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy did not rise after start");

  // Busy stays high for the first eight cycles after it rises
  property p_busy_hold;
    @(posedge ref_clk) disable iff (rst)
      $rose(busy) |-> busy [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("conversion aborted early");

  // Power-down request not taken during conversion
  property p_pwrdn_ignored;
    @(posedge ref_clk) disable iff (rst)
      (state_r == SACC_CONV) |=> $stable(pwrdn_r);
  endproperty
  a_pwrdn_ignored: assert property (p_pwrdn_ignored)
    else $error("power-down taken during conversion");

  // Start acts with read port deselected as well
  property p_start_nosel;
    @(posedge ref_clk) disable iff (rst)
      (s_start and rd_ctl.chip_select_n) |=> state_r == SACC_CONV;
  endproperty
  a_start_nosel: assert property (p_start_nosel)
    else $error("start refused while deselected");

  // Held start restarts after acquisition
  property p_auto;
    @(posedge ref_clk) disable iff (rst)
      (state_r == SACC_ACQ && acq_r <= 16'h0001 && start_held && !pwrdn_r)
        |=> busy;
  endproperty
  a_auto: assert property (p_auto)
    else $error("no automatic restart");

  // Deselect floats the bus
  property p_tristate;
    @(posedge ref_clk) disable iff (rst)
      (rd_ctl.chip_select_n || rd_ctl.read_enable_n) |=> data_oe == '0;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("bus driven while deselected");

  // Read in parallel mode drives the result
  property p_drive;
    @(posedge ref_clk) disable iff (rst)
      (rd_active && !serial) |=> (data_oe == '1 && data_out == $past(coded));
  endproperty
  a_drive: assert property (p_drive)
    else $error("result not driven");

  // Low current holds through acquisition and idle
  property p_lowpow;
    @(posedge ref_clk) disable iff (rst)
      (state_r == SACC_ACQ || state_r == SACC_IDLE) |-> core_low_power;
  endproperty
  a_lowpow: assert property (p_lowpow)
    else $error("core not in low current");

  // Result latched on the same edge that busy falls
  property p_code_first;
    @(posedge ref_clk) disable iff (rst)
      (state_r == SACC_DONE) |=> (result_r == $past(sar_r)) && !busy;
  endproperty
  a_code_first: assert property (p_code_first)
    else $error("busy fell before code formed");
endmodule // sacc_ctrl
`default_nettype wire

// *** verilog/sacc_map.svh ***
// Constant map for the SAR conversion control block
`ifndef SACC_MAP_SVH
`define SACC_MAP_SVH
`define SACC_RES_BITS 18
`define SACC_ACQ_NS 2000
`define SACC_CLK_NS 25
`define SACC_ACQ_CYC ((`SACC_ACQ_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS)
`define SACC_MODE_P18 2'h0
`define SACC_MODE_P16 2'h1
`define SACC_MODE_P8 2'h2
`define SACC_MODE_SER 2'h3
`endif

// *** verilog/sacc_pkg.sv ***
// Types for the SAR conversion control block
`default_nettype none
package sacc_pkg;
  typedef enum logic [1:0] {
    SACC_IDLE = 2'b00,
    SACC_CONV = 2'b01,
    SACC_DONE = 2'b10,
    SACC_ACQ = 2'b11
  } sacc_state_t;
  typedef struct packed {
    logic chip_select_n;
    logic read_enable_n;
    logic [1:0] mode;
    logic output_coding_select;
  } sacc_rd_ctl_t;
endpackage
`default_nettype wire
